// ===== rtl/terminal_port_local_echo.sv
// local echo engine with echo queue and start-up parameter query

////////////////////////////////////////////////////////////////////////////////
// small first-in first-out queue with valid and ready on both sides
module echo_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH]; // storage words
   logic [AW:0] wr_ptr_reg; // write pointer with wrap bit
   logic [AW:0] rd_ptr_reg; // read pointer with wrap bit
   wire logic full;
   wire logic empty;
   wire logic push;
   wire logic pop;

   // full when pointers differ only in the wrap bit
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
      && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
   assign push = in_valid && !full && ce;
   assign pop = out_valid && out_ready && ce;

   // pointer update
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

   // storage write, no reset needed
   always_ff @(posedge clk)
   begin
      if (push)
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// How it works
// - echo every received char on enabled ports
// - never echo XON or XOFF
// - carriage return echoed alone, no line feed
// - after power-up send parameter request sequence
// - group 5 reply field becomes echo mask
// - reset repeats request and reloads mask
module terminal_port_local_echo #(
   parameter int NUM_PORTS = echo_pkg::NUM_PORTS,
   parameter int FIFO_DEPTH = echo_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // characters from the terminal port receivers
   input wire logic rx_valid,
   output logic rx_ready,
   input wire echo_pkg::port_char_s rx_char,
   // characters queued by the host side for the terminals
   input wire logic host_valid,
   output logic host_ready,
   input wire echo_pkg::port_char_s host_char,
   // merged stream to the terminal port transmitters
   output logic tx_valid,
   input wire logic tx_ready,
   output echo_pkg::port_char_s tx_char,
   // characters sent to the configuration terminal
   output logic cfg_tx_valid,
   input wire logic cfg_tx_ready,
   output logic [7:0] cfg_tx_data,
   // characters received from the configuration terminal
   input wire logic cfg_rx_valid,
   input wire logic [7:0] cfg_rx_data,
   // current per-port echo enables and start-up done flag
   output logic [7:0] echo_mask,
   output logic config_done
);
   localparam int QW = $bits(echo_pkg::port_char_s);

   // true for codes that must not be echoed
   function automatic logic is_flow_char(input logic [7:0] c);
      is_flow_char = (c == echo_pkg::XON_CHAR)
         || (c == echo_pkg::XOFF_CHAR);
   endfunction

   // true for decimal digit codes
   function automatic logic is_digit(input logic [7:0] c);
      is_digit = (c >= echo_pkg::DIGIT_LO) && (c <= echo_pkg::DIGIT_HI);
   endfunction

   /////////////////////////////////////////////////////////////////////////////
   // start-up state
   echo_pkg::startup_e state_reg; // start-up phase
   echo_pkg::startup_e state_next;
   logic [1:0] req_idx_reg; // position in request sequence
   logic [3:0] field_reg; // reply field counter
   logic [7:0] value_reg; // decimal value being gathered
   logic [7:0] cand_reg; // group 5 value seen in this reply
   logic [7:0] mask_reg; // applied echo enables

   // request byte for the current position
   wire logic [7:0] req_byte;
   assign req_byte = (req_idx_reg == 2'h0) ? echo_pkg::ESC_CHAR :
                     (req_idx_reg == 2'h1) ? echo_pkg::CSI_CHAR :
                     (req_idx_reg == 2'h2) ? echo_pkg::REQ_ARG_CHAR :
                     echo_pkg::REQ_END_CHAR;

   // request is handed out straight from the sequencer
   assign cfg_tx_valid = (state_reg == echo_pkg::ST_REQUEST);
   assign cfg_tx_data = req_byte;
   wire logic req_step;
   assign req_step = cfg_tx_valid && cfg_tx_ready;
   wire logic req_done;
   assign req_done = req_step && (req_idx_reg == echo_pkg::REQ_LAST);

   // reply character classes
   wire logic rx_esc;
   wire logic rx_dig;
   wire logic rx_sep;
   wire logic rx_end;
   assign rx_esc = cfg_rx_valid && (cfg_rx_data == echo_pkg::ESC_CHAR);
   assign rx_dig = cfg_rx_valid && is_digit(cfg_rx_data);
   assign rx_sep = cfg_rx_valid && (cfg_rx_data == echo_pkg::SEP_CHAR);
   assign rx_end = cfg_rx_valid && (cfg_rx_data == echo_pkg::REQ_END_CHAR);

   // digit folded into running decimal value, ten times plus digit
   wire logic [7:0] digit;
   wire logic [7:0] value_acc;
   assign digit = cfg_rx_data - echo_pkg::DIGIT_LO;
   assign value_acc = {value_reg[4:0], 3'b000} + {value_reg[6:0], 1'b0}
      + digit;

   // field closes on separator or terminator
   wire logic field_close;
   wire logic field_hit;
   assign field_close = (state_reg == echo_pkg::ST_PARSE)
      && (rx_sep || rx_end);
   assign field_hit = field_close && (field_reg == echo_pkg::GROUP5_FIELD);

   // next start-up phase
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         echo_pkg::ST_REQUEST:
            if (req_done)
               state_next = echo_pkg::ST_WAIT_REPLY;
         echo_pkg::ST_WAIT_REPLY:
            if (rx_esc)
               state_next = echo_pkg::ST_PARSE;
         echo_pkg::ST_PARSE:
            if (rx_end)
               state_next = echo_pkg::ST_RUN;
            else if (rx_esc)
               state_next = echo_pkg::ST_PARSE;
         echo_pkg::ST_RUN:
            state_next = echo_pkg::ST_RUN;
      endcase
   end

   // phase and request position; reset restarts the query
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg <= echo_pkg::ST_REQUEST;
         req_idx_reg <= 2'h0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         if (req_step)
            req_idx_reg <= req_idx_reg + 2'h1;
      end
   end

   // reply field parsing
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         field_reg <= 4'h0;
         value_reg <= 8'h00;
         cand_reg <= echo_pkg::ECHO_MASK_RST;
      end
      else if (ce)
      begin
         // an escape restarts the reply
         if (rx_esc)
         begin
            field_reg <= 4'h0;
            value_reg <= 8'h00;
         end
         else if (state_reg == echo_pkg::ST_PARSE)
         begin
            if (rx_dig)
               value_reg <= value_acc;
            else if (field_close)
            begin
               field_reg <= field_reg + 4'h1;
               value_reg <= 8'h00;
            end
         end
         // keep the group 5 value for this reply
         if (field_hit)
            cand_reg <= value_reg;
      end
   end

   // mask applied only when the whole reply has arrived
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         mask_reg <= echo_pkg::ECHO_MASK_RST;
      else if (ce && (state_reg == echo_pkg::ST_PARSE) && rx_end)
         mask_reg <= field_hit ? value_reg : cand_reg;
   end

   assign echo_mask = mask_reg;
   assign config_done = (state_reg == echo_pkg::ST_RUN);

   /////////////////////////////////////////////////////////////////////////////
   // echo decision on the receive stream
   wire logic port_enabled;
   wire logic want_echo;
   wire logic q_in_ready;
   wire logic q_in_valid;
   // one mask bit per port selects echo
   assign port_enabled = (32'(rx_char.port) < NUM_PORTS)
      && mask_reg[rx_char.port];
   // flow-control codes are accepted from the receive stream but are never echoed
   assign want_echo = port_enabled
      && !is_flow_char(rx_char.data);
   // receive stalls only when an echo cannot be queued
   assign rx_ready = !want_echo || q_in_ready;
   // char queued unchanged, a return is queued once with no feed added
   assign q_in_valid = rx_valid && want_echo;

   /////////////////////////////////////////////////////////////////////////////
   // echo queue keeps receive order
   wire logic q_out_valid;
   wire logic q_out_ready;
   wire logic [QW-1:0] q_out_data;

   echo_fifo #(
      .WIDTH(QW),
      .DEPTH(FIFO_DEPTH)
   ) u_echo_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(q_in_valid),
      .in_ready(q_in_ready),
      .in_data(rx_char),
      .out_valid(q_out_valid),
      .out_ready(q_out_ready),
      .out_data(q_out_data)
   );

   /////////////////////////////////////////////////////////////////////////////
   // merge of echo and host characters into a registered output stage
   logic out_valid_reg; // output stage holds a char
   echo_pkg::port_char_s out_char_reg; // char on offer
   logic last_echo_reg; // last grant went to the echo queue

   wire logic stage_free;
   wire logic pick_echo;
   wire logic pick_host;
   // stage loads when empty or being drained
   assign stage_free = !out_valid_reg || tx_ready;
   // alternate when both wait so neither side is displaced
   assign pick_echo = q_out_valid
      && (!host_valid || !last_echo_reg);
   assign pick_host = host_valid && !pick_echo;
   assign q_out_ready = stage_free && pick_echo;
   assign host_ready = stage_free && pick_host;

   // output stage and fairness flag
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         out_valid_reg <= 1'b0;
         out_char_reg <= '0;
         last_echo_reg <= 1'b0;
      end
      else if (ce && stage_free)
      begin
         out_valid_reg <= q_out_valid || host_valid;
         // echo entry taken in queue order
         if (pick_echo)
         begin
            out_char_reg <= echo_pkg::port_char_s'(q_out_data);
            last_echo_reg <= 1'b1;
         end
         else if (pick_host)
         begin
            out_char_reg <= host_char;
            last_echo_reg <= 1'b0;
         end
      end
   end

   assign tx_valid = out_valid_reg;
   assign tx_char = out_char_reg;
endmodule

// ===== rtl/echo_pkg.sv
// shared constants and carriers for the terminal port local echo block
package echo_pkg;
   // port count and widths
   localparam int NUM_PORTS = 8;
   localparam int PORT_W = 3;
   localparam int CHAR_W = 8;
   localparam int FIFO_DEPTH = 4;

   // flow-control codes that never go back to the terminal
   localparam logic [7:0] XON_CHAR = 8'h11;
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   // carriage return and line feed codes
   localparam logic [7:0] CARRIAGE_RETURN_CHAR = 8'h0D;
   localparam logic [7:0] LINE_FEED_CHAR = 8'h0A;

   // parameter request sequence sent to the configuration terminal
   localparam logic [7:0] ESC_CHAR = 8'h1B;
   localparam logic [7:0] CSI_CHAR = 8'h5B;
   localparam logic [7:0] REQ_ARG_CHAR = 8'h30;
   localparam logic [7:0] REQ_END_CHAR = 8'h78;
   localparam int REQ_LEN = 4;
   localparam logic [1:0] REQ_LAST = 2'h3;

   // reply parsing: separator, terminator, digit range
   localparam logic [7:0] SEP_CHAR = 8'h3B;
   localparam logic [7:0] DIGIT_LO = 8'h30;
   localparam logic [7:0] DIGIT_HI = 8'h39;
   // reply field that holds the setting group 5 bits
   localparam logic [3:0] GROUP5_FIELD = 4'h6;

   // reset values
   localparam logic [7:0] ECHO_MASK_RST = 8'h00;

   // one character tagged with its terminal port
   typedef struct packed {
      logic [PORT_W-1:0] port;
      logic [CHAR_W-1:0] data;
   } port_char_s;

   // start-up states
   typedef enum logic [1:0] {
      ST_REQUEST,
      ST_WAIT_REPLY,
      ST_PARSE,
      ST_RUN
   } startup_e;
endpackage

// ===== sim/echo_properties.sv
// port checker for the local echo block
module echo_checker #(
   parameter int NUM_PORTS = 8,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire echo_pkg::port_char_s rx_char,
   input wire logic host_valid,
   input wire logic host_ready,
   input wire echo_pkg::port_char_s host_char,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire echo_pkg::port_char_s tx_char,
   input wire logic cfg_tx_valid,
   input wire logic cfg_tx_ready,
   input wire logic [7:0] cfg_tx_data,
   input wire logic cfg_rx_valid,
   input wire logic [7:0] cfg_rx_data,
   input wire logic [7:0] echo_mask,
   input wire logic config_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // one request byte taken
   sequence s_taken;
      ce && cfg_tx_valid && cfg_tx_ready;
   endsequence
   // request opens with escape after every reset
   req_start_a: assert property (
      $rose(rst_n) |-> cfg_tx_valid && cfg_tx_data == 8'h1B)
      else $error("request does not open with escape");
   req_order_a: assert property (
      (s_taken ##0 cfg_tx_data == 8'h1B) |=> cfg_tx_data == 8'h5B)
      else $error("second request byte wrong");
   req_next_a: assert property (
      (s_taken ##0 cfg_tx_data == 8'h5B)
      |=> cfg_tx_valid && cfg_tx_data == 8'h30)
      else $error("third request byte wrong");
   req_last_a: assert property (
      (s_taken ##0 cfg_tx_data == 8'h30)
      |=> cfg_tx_valid && cfg_tx_data == 8'h78)
      else $error("last request byte wrong");
   req_end_a: assert property (
      (s_taken ##0 cfg_tx_data == 8'h78) |=> !cfg_tx_valid [*8])
      else $error("request repeated");
   req_hold_a: assert property (
      cfg_tx_valid && !(ce && cfg_tx_ready)
      |=> cfg_tx_valid && $stable(cfg_tx_data))
      else $error("request byte dropped");
   tx_hold_a: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
      else $error("tx char not held");
   mask_clear_a: assert property (
      !config_done |-> echo_mask == 8'h00)
      else $error("mask set before reply");
   mask_keep_a: assert property (
      config_done |=> config_done && $stable(echo_mask))
      else $error("mask changed in run");
   rx_stall_a: assert property (
      !rx_ready |-> echo_mask[rx_char.port]
      && rx_char.data != echo_pkg::XON_CHAR
      && rx_char.data != echo_pkg::XOFF_CHAR)
      else $error("rx stalled needlessly");
   host_load_a: assert property (
      ce && host_valid && host_ready |=> tx_valid)
      else $error("host char lost");
endmodule
// checker attached to every instance of the echo block
bind terminal_port_local_echo echo_checker #(
   .NUM_PORTS(NUM_PORTS),
   .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (
   .clk(clk),
   .rst_n(rst_n),
   .ce(ce),
   .rx_valid(rx_valid),
   .rx_ready(rx_ready),
   .rx_char(rx_char),
   .host_valid(host_valid),
   .host_ready(host_ready),
   .host_char(host_char),
   .tx_valid(tx_valid),
   .tx_ready(tx_ready),
   .tx_char(tx_char),
   .cfg_tx_valid(cfg_tx_valid),
   .cfg_tx_ready(cfg_tx_ready),
   .cfg_tx_data(cfg_tx_data),
   .cfg_rx_valid(cfg_rx_valid),
   .cfg_rx_data(cfg_rx_data),
   .echo_mask(echo_mask),
   .config_done(config_done)
);

// ===== sim/cfg_terminal.sv
// behavioural configuration terminal answering the parameter request
module cfg_terminal (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cfg_tx_valid,
   input wire logic [7:0] cfg_tx_data,
   input wire logic [7:0] grp5,
   output logic cfg_tx_ready,
   output logic cfg_rx_valid,
   output logic [7:0] cfg_rx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] reply [18]; // reply, group 5 as field 6
   int got; // request bytes taken
   int idx; // next reply byte
   logic slow; // halves the pace
   // six dummy fields, then the group 5 bits in decimal
   always_comb
   begin
      reply = '{8'h1B, 8'h5B, 8'h31, 8'h3B, 8'h31, 8'h3B, 8'h31, 8'h3B,
         8'h31, 8'h3B, 8'h31, 8'h3B, 8'h31, 8'h3B, 8'h30 + grp5 / 8'd100,
         8'h30 + grp5 / 8'd10 % 8'd10, 8'h30 + grp5 % 8'd10, 8'h78};
   end
   // slow handshake; data toggles when no char is offered
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         {got, idx, slow, cfg_tx_ready, cfg_rx_valid} <= '0;
         cfg_rx_data <= 8'h00;
      end
      else
      begin
         slow <= ~slow;
         cfg_tx_ready <= slow;
         cfg_rx_valid <= 1'b0;
         cfg_rx_data <= ~cfg_rx_data;
         if (cfg_tx_valid && cfg_tx_ready)
            got <= got + 1;
         if (got == 4 && slow && idx < 18)
         begin
            cfg_rx_valid <= 1'b1;
            cfg_rx_data <= reply[idx];
            idx <= idx + 1;
         end
      end
   end
endmodule

// ===== sim/tb.sv
// self-checking bench for the local echo block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, ce, rx_valid, rx_ready, host_valid, host_ready;
   logic tx_valid, tx_ready, cfg_tx_valid, cfg_tx_ready, cfg_rx_valid;
   logic config_done, rx_took, host_took;
   logic [7:0] cfg_tx_data, cfg_rx_data, echo_mask, grp5;
   echo_pkg::port_char_s rx_char, host_char, tx_char;
   echo_pkg::port_char_s eq[$], hq[$]; // expected echoes and host chars
   logic [7:0] corner [4] = '{8'h11, 8'h13, 8'h0D, 8'h0A};
   integer seed = 32'h46fcca2f;
   int err_total = 0;
   int n_checks = 0;
   int test_no = 0;
   terminal_port_local_echo DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_char(rx_char),
      .host_valid(host_valid), .host_ready(host_ready),
      .host_char(host_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_char(tx_char), .cfg_tx_valid(cfg_tx_valid),
      .cfg_tx_ready(cfg_tx_ready), .cfg_tx_data(cfg_tx_data),
      .cfg_rx_valid(cfg_rx_valid), .cfg_rx_data(cfg_rx_data),
      .echo_mask(echo_mask), .config_done(config_done));
   cfg_terminal u_term (.clk(clk), .rst_n(rst_n), .cfg_tx_valid(cfg_tx_valid),
      .cfg_tx_data(cfg_tx_data), .grp5(grp5), .cfg_tx_ready(cfg_tx_ready),
      .cfg_rx_valid(cfg_rx_valid), .cfg_rx_data(cfg_rx_data));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // compare and count
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // whether a received char must come back
   function bit echoes(echo_pkg::port_char_s c, logic [7:0] m);
      return m[c.port] && c.data != 8'h11 && c.data != 8'h13;
   endfunction
   // scoreboard of everything taken and sent
   always @(posedge clk)
   begin
      rx_took = rx_valid && rx_ready && ce && rst_n;
      host_took = host_valid && host_ready && ce && rst_n;
      if (rx_took && echoes(rx_char, grp5))
         eq.push_back(rx_char);
      if (host_took)
         hq.push_back(host_char);
      if (rst_n && ce && tx_valid && tx_ready)
      begin
         if (eq.size() != 0 && tx_char === eq[0])
            check(16'(tx_char), 16'(eq.pop_front()));
         else if (hq.size() != 0)
            check(16'(tx_char), 16'(hq.pop_front()));
         else
            check(16'(tx_char), 16'hFFFF);
      end
   end
   // reset, then await the reply
   task do_reset(input logic [7:0] m);
      grp5 = m;
      ce = 1'b1;
      rst_n = 1'b0;
      // reset abandons any offer still standing
      rx_valid = 1'b0;
      host_valid = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      eq.delete();
      hq.delete();
      for (int i = 0; i < 300 && config_done !== 1'b1; i++)
         @(negedge clk);
      check(16'(echo_mask), 16'(m));
      check(16'(config_done), 16'h0001);
   endtask
   // random traffic; a request is held until taken
   task traffic(input int n, input logic go);
      logic [31:0] r;
      repeat (n)
      begin
         @(negedge clk);
         r = $random(seed);
         ce = r[31:29] != 3'h0;
         tx_ready = r[2] | (r[3] & go);
         if (!rx_valid || rx_took)
         begin
            rx_valid = r[0];
            rx_char.port = r[6:4];
            rx_char.data = r[9:8] == 2'h0 ? corner[r[11:10]] : r[19:12];
         end
         if (!host_valid || host_took)
         begin
            host_valid = r[1];
            host_char = r[30:20];
         end
      end
   endtask
   // let all queued chars out, nothing may remain
   task drain;
      // offers still standing are held until taken, then dropped
      repeat (40)
      begin
         @(negedge clk);
         {ce, tx_ready} = 2'b11;
         if (rx_took)
            rx_valid = 1'b0;
         if (host_took)
            host_valid = 1'b0;
      end
      check(16'(eq.size()), 16'h0000);
      check(16'(hq.size()), 16'h0000);
      test_no++;
      $display("test %0d done, checks %0d", test_no, n_checks);
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      {rst_n, ce, rx_valid, host_valid, tx_ready} = '0;
      rx_char = '0;
      host_char = '0;
      grp5 = 8'h00;
      do_reset(8'h05);
      traffic(400, 1'b1);
      drain();
      traffic(300, 1'b0);
      drain();
      traffic(80, 1'b0);
      do_reset(8'hFF); // mid-run reset
      traffic(400, 1'b1);
      drain();
      do_reset(8'h00);
      traffic(100, 1'b1);
      drain();
      results();
   end
   // cut a hang short
   initial
   begin
      #(100 * 20000);
      err_total++;
      results();
   end
endmodule
